// ### core/crf_pkg.sv
package crf_pkg;

  // Register and address widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W   = 16;
  localparam int unsigned ADDR_W = 8;

  // Reset values
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [7:0]  IDX_RST   = 8'h00;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [7:0]  SP_RST    = 8'h00;
  localparam logic [7:0]  FLAGS_RST = 8'h02;

  // Register space
  localparam logic [7:0] FLAGS_ADDR = 8'hF7;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;

  // Flag field positions
  localparam int unsigned FLAG_GIE_BIT  = 0;
  localparam int unsigned FLAG_ZERO_BIT = 1;
  localparam int unsigned FLAG_CARRY_BIT = 2;
  localparam int unsigned FLAG_BANK_BIT = 4;
  localparam int unsigned FLAG_BANK1_BIT = 5;
  // Bit 3 is reserved and always reads zero
  localparam logic [7:0] FLAGS_MASK = 8'hF7;

  localparam logic [7:0] SP_STEP = 8'h01;

  // Dedicated operations
  typedef enum logic [3:0] {
    CRF_OP_NOP    = 4'b0000,
    CRF_OP_LD_A   = 4'b0001,
    CRF_OP_LD_X   = 4'b0010,
    CRF_OP_SWAP   = 4'b0011,
    CRF_OP_OR_F   = 4'b0100,
    CRF_OP_AND_F  = 4'b0101,
    CRF_OP_XOR_F  = 4'b0110,
    CRF_OP_JMP    = 4'b0111,
    CRF_OP_PUSH_A = 4'b1000,
    CRF_OP_PUSH_X = 4'b1001,
    CRF_OP_POP_A  = 4'b1010,
    CRF_OP_POP_X  = 4'b1011
  } crf_op_t;

endpackage : crf_pkg

// ### core/crf_stk_if.sv
interface crf_stk_if;
  import crf_pkg::*;
  logic              wr_en;
  logic              rd_en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;

  modport ctrl (output wr_en, output rd_en, output addr, output wdata, input rdata);
  modport mem  (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface : crf_stk_if

// ### core/crf_stack_ram.sv
module crf_stack_ram
  import crf_pkg::*;
(
  // Clock
  input wire logic i_clock,
  // Stack port
  crf_stk_if.mem   stk
);

  localparam int unsigned DEPTH = 2 ** ADDR_W;

  logic [DATA_W-1:0] mem_reg [DEPTH];
  logic [DATA_W-1:0] rdata_reg;

  always_ff @(posedge i_clock) begin
    if (stk.wr_en) begin
      mem_reg[stk.addr] <= stk.wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (stk.rd_en) begin
      rdata_reg <= mem_reg[stk.addr];
    end
  end

  assign stk.rdata = rdata_reg;

endmodule : crf_stack_ram

// ### core/crf_core_regs.sv
// Overview of operation
// (RULE_01) A, X, SP, flags 8-bit; PC 16-bit
// (RULE_02) Reset clears A, X, PC, SP
// (RULE_03) Reset loads flags with 02h
// (RULE_04) Push/pop step stack pointer automatically
// (RULE_05) Stack pointer wraps FFh to 00h silently
// (RULE_06) Only flags visible in register space
// (RULE_07) Registers change only via dedicated operations
// (RULE_08) Flags read at F7h in both banks
// (RULE_09) Bank-independent registers decode ignoring bank
// (RULE_10) AND, OR, XOR immediate modify flags
// (RULE_11) Bank flag set selects bank 1
// (RULE_12) Zero flag lives at bit 1
module crf_core_regs
  import crf_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  // Operation port
  input  wire logic              i_op_valid,
  input  wire crf_op_t           i_op,
  input  wire logic [DATA_W-1:0] i_imm,
  input  wire logic [PC_W-1:0]   i_jump_addr,
  // Register space port
  input  wire logic              i_reg_rd,
  input  wire logic              i_reg_wr,
  input  wire logic [ADDR_W-1:0] i_reg_addr,
  input  wire logic              i_reg_bank,
  input  wire logic [DATA_W-1:0] i_reg_wdata,
  output logic [DATA_W-1:0]      o_reg_rdata,
  output logic                   o_reg_ack,
  output logic                   o_reg_hit,
  // Register contents
  output logic [DATA_W-1:0]      o_acc,
  output logic [DATA_W-1:0]      o_idx,
  output logic [PC_W-1:0]        o_pc,
  output logic [DATA_W-1:0]      o_sp,
  output logic [DATA_W-1:0]      o_flags,
  output logic                   o_bank_sel,
  output logic                   o_busy
);

  // (RULE_01) register widths
  logic [DATA_W-1:0] acc_reg;
  logic [DATA_W-1:0] idx_reg;
  logic [PC_W-1:0]   pc_reg;
  logic [DATA_W-1:0] sp_reg;
  logic [DATA_W-1:0] flags_reg;
  logic [DATA_W-1:0] flags_next;
  logic              pop_a_reg;
  logic              pop_x_reg;
  logic              busy_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic              ack_reg;
  logic              hit_reg;
  logic              op_go;
  logic              flags_addr_hit;

  crf_stk_if stk ();

  crf_stack_ram u_stack (
    .i_clock (i_clock),
    .stk     (stk)
  );

  // Operations are refused while a pop result is landing
  assign op_go = i_op_valid && !(pop_a_reg || pop_x_reg);

  // (RULE_04) push writes at SP, pop reads at SP minus one
  always_comb begin
    stk.wr_en = op_go && (i_op == CRF_OP_PUSH_A || i_op == CRF_OP_PUSH_X);
    stk.rd_en = op_go && (i_op == CRF_OP_POP_A || i_op == CRF_OP_POP_X);
    stk.wdata = (i_op == CRF_OP_PUSH_X) ? idx_reg : acc_reg;
    stk.addr  = stk.rd_en ? (sp_reg - SP_STEP) : sp_reg;
  end

  // (RULE_02) accumulator load, exchange and pop
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      acc_reg <= ACC_RST;
    end else if (pop_a_reg) begin
      acc_reg <= stk.rdata;
    end else if (op_go && i_op == CRF_OP_LD_A) begin
      acc_reg <= i_imm;
    end else if (op_go && i_op == CRF_OP_SWAP) begin
      acc_reg <= sp_reg;
    end
  end

  // (RULE_07) index changes only by load or pop
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      idx_reg <= IDX_RST;
    end else if (pop_x_reg) begin
      idx_reg <= stk.rdata;
    end else if (op_go && i_op == CRF_OP_LD_X) begin
      idx_reg <= i_imm;
    end
  end

  // (RULE_07) program counter changes only by jump
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pc_reg <= PC_RST;
    end else if (op_go && i_op == CRF_OP_JMP) begin
      pc_reg <= i_jump_addr;
    end
  end

  // (RULE_05) 8-bit step wraps with no fault
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sp_reg <= SP_RST;
    end else if (stk.wr_en) begin
      sp_reg <= sp_reg + SP_STEP;
    end else if (stk.rd_en) begin
      sp_reg <= sp_reg - SP_STEP;
    end else if (op_go && i_op == CRF_OP_SWAP) begin
      sp_reg <= acc_reg;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pop_a_reg <= 1'b0;
      pop_x_reg <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      pop_a_reg <= stk.rd_en && i_op == CRF_OP_POP_A;
      pop_x_reg <= stk.rd_en && i_op == CRF_OP_POP_X;
      busy_reg  <= stk.rd_en;
    end
  end

  // (RULE_10) logic operations on flags
  always_comb begin
    flags_next = flags_reg;
    if (op_go) begin
      case (i_op)
        CRF_OP_OR_F:  flags_next = (flags_reg | i_imm) & FLAGS_MASK;
        CRF_OP_AND_F: flags_next = (flags_reg & i_imm) & FLAGS_MASK;
        CRF_OP_XOR_F: flags_next = (flags_reg ^ i_imm) & FLAGS_MASK;
        default:      flags_next = flags_reg;
      endcase
    end
  end

  // (RULE_12) zero flag at bit 1
  // (RULE_03) flags reset to zero flag only
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      flags_reg <= FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // (RULE_09) bank input ignored for flags decode
  assign flags_addr_hit = (i_reg_addr == FLAGS_ADDR);

  // (RULE_08) register-space read of flags
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rdata_reg <= ZERO_BYTE;
      ack_reg   <= 1'b0;
      hit_reg   <= 1'b0;
    end else begin
      ack_reg <= i_reg_rd || i_reg_wr;
      hit_reg <= (i_reg_rd || i_reg_wr) && flags_addr_hit;
      // (RULE_06) nothing else mapped
      rdata_reg <= (i_reg_rd && flags_addr_hit) ? flags_reg : ZERO_BYTE;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_reg_ack   = ack_reg;
  assign o_reg_hit   = hit_reg;
  assign o_acc       = acc_reg;
  assign o_idx       = idx_reg;
  assign o_pc        = pc_reg;
  assign o_sp        = sp_reg;
  assign o_flags     = flags_reg;
  // (RULE_11) bank select from flag bit
  assign o_bank_sel  = flags_reg[FLAG_BANK_BIT];
  assign o_busy      = busy_reg;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  logic rst_seen_reg;
  always_ff @(posedge i_clock) begin
    rst_seen_reg <= i_rst_n;
  end

  reset_vals_a: assert property (!rst_seen_reg && i_rst_n |-> acc_reg == ACC_RST // RULE_02
    && sp_reg == SP_RST && pc_reg == PC_RST && idx_reg == IDX_RST)
    else $error("core regs not cleared by reset");
  reset_flags_a: assert property (!rst_seen_reg && i_rst_n |-> flags_reg == FLAGS_RST // RULE_03
    && flags_reg[FLAG_ZERO_BIT]) else $error("flags reset value wrong");
  push_step_a: assert property (stk.wr_en |=> sp_reg == $past(sp_reg) + SP_STEP) // RULE_04
    else $error("push did not advance stack pointer");
  pop_return_a: assert property (op_go && i_op == CRF_OP_PUSH_A ##1 // RULE_04
    op_go && i_op == CRF_OP_POP_A |-> ##2 acc_reg == $past(acc_reg, 2))
    else $error("pop did not return pushed byte");
  sp_wrap_a: assert property (stk.wr_en && sp_reg == 8'hFF |=> sp_reg == 8'h00) // RULE_05
    else $error("stack pointer did not wrap");
  flags_read_a: assert property (i_reg_rd && i_reg_addr == FLAGS_ADDR // RULE_08
    |=> o_reg_rdata == $past(flags_reg) && o_reg_hit) else $error("flags read wrong");
  unmapped_read_a: assert property (i_reg_rd && i_reg_addr != FLAGS_ADDR // RULE_06
    |=> o_reg_rdata == ZERO_BYTE && !o_reg_hit) else $error("unmapped read returned data");
  flags_or_a: assert property (op_go && i_op == CRF_OP_OR_F // RULE_10
    |=> flags_reg == (($past(flags_reg) | $past(i_imm)) & FLAGS_MASK))
    else $error("flag OR wrong");
  pc_hold_a: assert property (!(op_go && i_op == CRF_OP_JMP) |=> $stable(pc_reg)) // RULE_07
    else $error("program counter changed without jump");
  bank_sel_a: assert property (op_go && i_op == CRF_OP_XOR_F && i_imm[FLAG_BANK_BIT] // RULE_11
    |=> o_bank_sel != $past(o_bank_sel)) else $error("bank select did not follow flag");

  push_pop_c: cover property (stk.wr_en ##1 stk.rd_en);
  wrap_c: cover property (stk.wr_en && sp_reg == 8'hFF);
  bank1_read_c: cover property (i_reg_rd && i_reg_bank && flags_addr_hit);
  swap_c: cover property (op_go && i_op == CRF_OP_SWAP);

endmodule : crf_core_regs

// ### dv/crf_core_regs_tb.sv
module crf_core_regs_tb
  import crf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              i_clock, i_rst_n, i_op_valid, i_reg_rd, i_reg_wr, i_reg_bank;
  crf_op_t           i_op;
  logic [DATA_W-1:0] i_imm, i_reg_addr, i_reg_wdata;
  logic [PC_W-1:0]   i_jump_addr;
  logic [DATA_W-1:0] o_reg_rdata, o_acc, o_idx, o_sp, o_flags;
  logic [PC_W-1:0]   o_pc;
  logic              o_reg_ack, o_reg_hit, o_bank_sel, o_busy;
  int                fail_count, samples_checked;

  crf_core_regs dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_op_valid(i_op_valid), .i_op(i_op),
    .i_imm(i_imm), .i_jump_addr(i_jump_addr), .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr),
    .i_reg_addr(i_reg_addr), .i_reg_bank(i_reg_bank), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack), .o_reg_hit(o_reg_hit),
    .o_acc(o_acc), .o_idx(o_idx), .o_pc(o_pc), .o_sp(o_sp), .o_flags(o_flags),
    .o_bank_sel(o_bank_sel), .o_busy(o_busy)
  );

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic do_op(input crf_op_t op, input logic [7:0] imm, input logic [15:0] ja);
    @(negedge i_clock);
    i_op_valid  = 1'b1;
    i_op        = op;
    i_imm       = imm;
    i_jump_addr = ja;
    @(negedge i_clock);
    i_op_valid  = 1'b0;
  endtask : do_op

  // Register-space access, answer one cycle later
  task automatic acc(input logic w, input logic [7:0] a, input logic b,
                     input logic [7:0] exp, input logic hit);
    @(negedge i_clock);
    i_reg_rd    = ~w;
    i_reg_wr    = w;
    i_reg_addr  = a;
    i_reg_bank  = b;
    i_reg_wdata = 8'hFF;
    @(negedge i_clock);
    i_reg_rd    = 1'b0;
    i_reg_wr    = 1'b0;
    chk("ack", 16'h0001, {15'h0000, o_reg_ack});
    chk("hit", {15'h0000, hit}, {15'h0000, o_reg_hit});
    if (!w) chk("rdata", {8'h00, exp}, {8'h00, o_reg_rdata});
  endtask : acc

  // Pop with an op offered during the busy cycle
  task automatic pop(input crf_op_t op, input logic [7:0] exp, input logic [7:0] sp);
    @(negedge i_clock);
    i_op_valid = 1'b1;
    i_op       = op;
    @(negedge i_clock);
    chk("busy", 16'h0001, {15'h0000, o_busy});
    chk("sp_pop", {8'h00, sp}, {8'h00, o_sp});
    i_op = CRF_OP_PUSH_A;
    @(negedge i_clock);
    i_op_valid = 1'b0;
    chk("pop_data", {8'h00, exp}, op == CRF_OP_POP_X ? {8'h00, o_idx} : {8'h00, o_acc});
    chk("sp_refused", {8'h00, sp}, {8'h00, o_sp});
    chk("busy_end", 16'h0000, {15'h0000, o_busy});
  endtask : pop

  task automatic t_reset();
    chk("acc", 16'h0000, {8'h00, o_acc});
    chk("idx", 16'h0000, {8'h00, o_idx});
    chk("pc", PC_RST, o_pc);
    chk("sp", 16'h0000, {8'h00, o_sp});
    chk("flags", 16'h0002, {8'h00, o_flags});
    chk("zero", 16'h0001, {15'h0000, o_flags[FLAG_ZERO_BIT]});
    $display("t_reset done");
  endtask : t_reset

  task automatic t_regspace();
    acc(1'b0, 8'hF7, 1'b0, 8'h02, 1'b1);
    acc(1'b0, 8'hF7, 1'b1, 8'h02, 1'b1);
    acc(1'b1, 8'hF7, 1'b1, 8'h00, 1'b1);
    acc(1'b0, 8'hF7, 1'b0, 8'h02, 1'b1);
    $display("t_regspace done");
  endtask : t_regspace

  task automatic t_ops();
    do_op(CRF_OP_LD_A, 8'hA5, 16'h0000);
    do_op(CRF_OP_LD_X, 8'h3C, 16'h0000);
    do_op(CRF_OP_JMP, 8'h00, 16'hFFFF);
    chk("acc_ld", 16'h00A5, {8'h00, o_acc});
    chk("idx_ld", 16'h003C, {8'h00, o_idx});
    chk("pc_jmp", 16'hFFFF, o_pc);
    acc(1'b0, 8'h00, 1'b0, 8'h00, 1'b0);
    acc(1'b0, 8'hF6, 1'b1, 8'h00, 1'b0);
    do_op(CRF_OP_SWAP, 8'h00, 16'h0000);
    chk("acc_swap", 16'h0000, {8'h00, o_acc});
    chk("sp_swap", 16'h00A5, {8'h00, o_sp});
    $display("t_ops done");
  endtask : t_ops

  task automatic t_flags();
    do_op(CRF_OP_OR_F, 8'h10, 16'h0000);
    chk("flags_or", 16'h0012, {8'h00, o_flags});
    chk("bank1", 16'h0001, {15'h0000, o_bank_sel});
    acc(1'b0, 8'hF7, 1'b1, 8'h12, 1'b1);
    do_op(CRF_OP_XOR_F, 8'h18, 16'h0000);
    chk("flags_xor", {8'h00, 8'h0A & FLAGS_MASK}, {8'h00, o_flags});
    chk("bank0", 16'h0000, {15'h0000, o_bank_sel});
    do_op(CRF_OP_AND_F, 8'hFD, 16'h0000);
    chk("flags_and", 16'h0000, {8'h00, o_flags});
    $display("t_flags done");
  endtask : t_flags

  task automatic t_stack();
    do_op(CRF_OP_LD_A, 8'hFF, 16'h0000);
    do_op(CRF_OP_SWAP, 8'h00, 16'h0000);
    do_op(CRF_OP_LD_A, 8'h77, 16'h0000);
    do_op(CRF_OP_PUSH_A, 8'h00, 16'h0000);
    chk("sp_wrap", 16'h0000, {8'h00, o_sp});
    pop(CRF_OP_POP_X, 8'h77, 8'hFF);
    do_op(CRF_OP_LD_X, 8'h5E, 16'h0000);
    do_op(CRF_OP_PUSH_X, 8'h00, 16'h0000);
    chk("sp_push", 16'h0000, {8'h00, o_sp});
    pop(CRF_OP_POP_A, 8'h5E, 8'hFF);
    $display("t_stack done");
  endtask : t_stack

  // Push then pop A on consecutive edges
  task automatic t_push_pop();
    do_op(CRF_OP_LD_A, 8'h3A, 16'h0000);
    @(negedge i_clock);
    i_op_valid = 1'b1;
    i_op       = CRF_OP_PUSH_A;
    @(negedge i_clock);
    i_op       = CRF_OP_POP_A;
    chk("sp_b2b_push", 16'h0000, {8'h00, o_sp});
    @(negedge i_clock);
    i_op_valid = 1'b0;
    chk("sp_b2b_pop", 16'h00FF, {8'h00, o_sp});
    @(negedge i_clock);
    chk("acc_b2b_pop", 16'h003A, {8'h00, o_acc});
    $display("t_push_pop done");
  endtask : t_push_pop

  // Reset again from a loaded state
  task automatic t_midreset();
    @(negedge i_clock);
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_clock);
    i_rst_n = 1'b1;
    t_reset();
    $display("t_midreset done");
  endtask : t_midreset

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  initial begin
    fail_count      = 0;
    samples_checked = 0;
    i_rst_n         = 1'b0;
    i_op_valid      = 1'b0;
    i_op            = CRF_OP_NOP;
    i_imm           = 8'h00;
    i_jump_addr     = 16'h0000;
    i_reg_rd        = 1'b0;
    i_reg_wr        = 1'b0;
    i_reg_addr      = 8'h00;
    i_reg_bank      = 1'b0;
    i_reg_wdata     = 8'h00;
    repeat (10) @(negedge i_clock);
    i_rst_n = 1'b1;
    t_reset();
    t_regspace();
    t_ops();
    t_flags();
    t_stack();
    t_push_pop();
    t_midreset();
    summarize();
  end
endmodule : crf_core_regs_tb
